// ===== utrd_pkg.sv
// shared constants and carrier types for the serial transmit/receive data path
// assumes a single system clock; registers are word aligned on a 32-bit bus
package utrd_pkg;
    // register byte offsets
    localparam logic [4:0] UTRD_OFS_DATA = 5'h00;
    localparam logic [4:0] UTRD_OFS_STAT = 5'h04;
    localparam logic [4:0] UTRD_OFS_CTRL = 5'h08;
    localparam logic [4:0] UTRD_OFS_BAUD = 5'h0C;
    // status bit positions
    localparam int UTRD_ST_TBE = 0;
    localparam int UTRD_ST_TDONE = 1;
    localparam int UTRD_ST_RFULL = 2;
    localparam int UTRD_ST_RX9 = 3;
    // reset values: eight-bit characters, everything disabled
    localparam logic [12:0] UTRD_CTRL_RST = 13'h00C0;
    localparam logic [15:0] UTRD_BAUD_RST = 16'h0103;
    // character size codes
    localparam logic [2:0] UTRD_SIZE_NINE = 3'h7;
    localparam logic [3:0] UTRD_NB_BASE = 4'h5;
    localparam logic [3:0] UTRD_NB_NINE = 4'h9;
    // control register layout, bit 0 at the bottom
    typedef struct packed {
        logic sync_mode;
        logic two_stop;
        logic parity_odd;
        logic parity_mode_hi;
        logic [2:0] char_size_sel;
        logic tx_ninth_bit;
        logic rx_complete_irq_en;
        logic tx_complete_irq_en;
        logic tx_buffer_empty_irq_en;
        logic receiver_enable;
        logic transmitter_enable;
    } utrd_ctrl_t;
    // one character with its ninth bit
    typedef struct packed {
        logic ninth;
        logic [7:0] low;
    } utrd_char_t;
    // frame sequencer states, shared by both directions
    typedef enum logic [4:0] {
        UTRD_IDLE = 5'h01,
        UTRD_START = 5'h02,
        UTRD_DATA = 5'h04,
        UTRD_PAR = 5'h08,
        UTRD_STOP = 5'h10
    } utrd_st_t;
endpackage

// ===== utrd_datapath.sv
// serial port transmit and receive data path with flags and interrupt requests
// assumes a classic wishbone master on clk_i; rxd_i and xck_i are asynchronous pins
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
// Operation
// - the ninth bit may mark an address frame or carry protocol information
// - buffer-empty flag is high while the transmit buffer is empty, low while full
// - buffer-empty request stays up while its enable and the flag are set
// - a data write loads the transmit buffer and clears the buffer-empty flag
// - transmit-complete sets when the frame is out and the buffer is empty
// - transmit-complete clears on interrupt acknowledge or a written one
// - transmit-complete request follows the flag when its enable is set
// - with the upper parity bit set, parity goes between data and stop bits
// - clearing the transmitter enable waits until shifter and buffer are drained
// - once really disabled the transmitter releases the transmit pin
// - receiver enable makes the receive pin the serial input
// - in synchronous mode the receiver samples on the transfer clock pin
// - receiver starts on a valid start bit and shifts bits up to the stop
// - a second stop bit is ignored; the frame ends at the first stop
// - at the first stop bit the shifter moves into the receive buffer
// - unused upper data bits read as zero for short characters
// - the shifter loads when idle or right after the last stop bit
// - upper written data bits are ignored for short characters
// - receive-complete shows unread data; disabling the receiver flushes it
// - parity is the xor of data bits, inverted when odd; lsb first
module utrd_datapath
    import utrd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic txd_o,
    output logic txd_oe_o,
    input wire logic rxd_i,
    output logic rx_pin_own_o,
    input wire logic xck_i,
    input wire logic tdone_ack_i,
    output logic tbe_irq_o,
    output logic tdone_irq_o,
    output logic rfull_irq_o
);
    logic ack_r;
    logic [31:0] dat_r;
    logic acc;
    logic wr_data;
    logic rd_data;
    logic wr_stat;
    logic [12:0] ctrl_r;
    utrd_ctrl_t cf;
    logic [15:0] baud_r;
    logic [3:0] nbits;
    logic [8:0] dmask;
    logic rxd_m_r;
    logic rxd_s_r;
    logic xck_m_r;
    logic xck_s_r;
    logic xck_d_r;
    logic xck_rise;
    logic xck_fall;
    utrd_char_t buf_r;
    logic buf_full_r;
    logic tdone_r;
    logic transmitter_enable_eff_r;
    utrd_st_t tx_st_r;
    logic [8:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic tx_par_r;
    logic tx_stop2_r;
    logic [15:0] tx_div_r;
    logic tx_tick;
    logic tx_last;
    logic tx_load;
    logic txd_r;
    logic txd_oe_r;
    utrd_st_t rx_st_r;
    logic [8:0] rx_sh_r;
    logic [3:0] rx_cnt_r;
    logic [15:0] rx_div_r;
    logic rx_samp;
    logic rx_done;
    utrd_char_t rxb_r;
    logic rx_full_r;
    logic rx_own_r;
    logic tbe_irq_r;
    logic tdone_irq_r;
    logic rfull_irq_r;

    // bus decode; a write or a pop happens at the edge where the master sees ack
    assign acc = wb_cyc_i & wb_stb_i & ack_r;
    assign wr_data = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == UTRD_OFS_DATA);
    assign rd_data = acc & ~wb_we_i & (wb_adr_i == UTRD_OFS_DATA);
    assign wr_stat = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == UTRD_OFS_STAT);
    assign cf = utrd_ctrl_t'(ctrl_r);

    // character length and mask of valid data bits
    assign nbits = (cf.char_size_sel == UTRD_SIZE_NINE) ? UTRD_NB_NINE
                 : UTRD_NB_BASE + {2'b00, cf.char_size_sel[1:0]};
    assign dmask = ~(9'h1FF << nbits);

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
        end
    end

    // read data captured with ack; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
            unique case (wb_adr_i)
                UTRD_OFS_DATA: dat_r <= {24'h00_0000, rxb_r.low};
                UTRD_OFS_STAT: dat_r <= {28'h000_0000, rxb_r.ninth, rx_full_r, tdone_r,
                                         ~buf_full_r};
                UTRD_OFS_CTRL: dat_r <= {19'h0_0000, ctrl_r};
                UTRD_OFS_BAUD: dat_r <= {16'h0000, baud_r};
                default: dat_r <= 32'h0000_0000;
            endcase
        end
    end

    // control and divisor registers, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= UTRD_CTRL_RST;
            baud_r <= UTRD_BAUD_RST;
        end else if (acc & wb_we_i) begin
            if (wb_adr_i == UTRD_OFS_CTRL) begin
                if (wb_sel_i[0]) begin
                    ctrl_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl_r[12:8] <= wb_dat_i[12:8];
                end
            end
            if (wb_adr_i == UTRD_OFS_BAUD) begin
                if (wb_sel_i[0]) begin
                    baud_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    baud_r[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // pin synchronisers; the second stage is looked at, plus a third stage for transfer clock edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            xck_m_r <= 1'b0;
            xck_s_r <= 1'b0;
            xck_d_r <= 1'b0;
        end else begin
            rxd_m_r <= rxd_i;
            rxd_s_r <= rxd_m_r;
            xck_m_r <= xck_i;
            xck_s_r <= xck_m_r;
            xck_d_r <= xck_s_r;
        end
    end
    assign xck_rise = xck_s_r & ~xck_d_r;
    assign xck_fall = ~xck_s_r & xck_d_r;

    // transmit bit timing: divisor in async mode, falling transfer clock in sync mode
    assign tx_tick = cf.sync_mode ? xck_fall : (tx_div_r == 16'h0000);
    assign tx_last = (tx_st_r == UTRD_STOP) & tx_tick & (~cf.two_stop | tx_stop2_r);
    assign tx_load = buf_full_r & transmitter_enable_eff_r & ((tx_st_r == UTRD_IDLE) | tx_last);

    // divisor restarts while idle so each frame starts with a whole start bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_div_r <= UTRD_BAUD_RST;
        end else if ((tx_st_r == UTRD_IDLE) | (tx_div_r == 16'h0000)) begin
            tx_div_r <= baud_r;
        end else begin
            tx_div_r <= tx_div_r - 16'h0001;
        end
    end

    // transmit buffer; a write while the shifter loads still wins the buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_full_r <= 1'b0;
            buf_r <= '0;
        end else if (wr_data) begin
            buf_full_r <= 1'b1;
            buf_r <= utrd_char_t'({cf.tx_ninth_bit, wb_dat_i[7:0]} & dmask);
        end else if (tx_load) begin
            buf_full_r <= 1'b0;
        end
    end

    // shifter load with parity over the masked character
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sh_r <= 9'h000;
            tx_par_r <= 1'b0;
        end else if (tx_load) begin
            tx_sh_r <= buf_r;
            tx_par_r <= ^buf_r ^ cf.parity_odd;
        end
    end

    // transmit frame sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_r <= UTRD_IDLE;
            tx_cnt_r <= 4'h0;
            tx_stop2_r <= 1'b0;
        end else begin
            unique case (tx_st_r)
                UTRD_IDLE: begin
                    if (tx_load) begin
                        tx_st_r <= UTRD_START;
                    end
                end
                UTRD_START: begin
                    tx_stop2_r <= 1'b0;
                    if (tx_tick) begin
                        tx_st_r <= UTRD_DATA;
                        tx_cnt_r <= 4'h0;
                    end
                end
                UTRD_DATA: begin
                    if (tx_tick) begin
                        if (tx_cnt_r == nbits - 4'h1) begin
                            tx_st_r <= cf.parity_mode_hi ? UTRD_PAR : UTRD_STOP;
                        end else begin
                            tx_cnt_r <= tx_cnt_r + 4'h1;
                        end
                    end
                end
                UTRD_PAR: begin
                    if (tx_tick) begin
                        tx_st_r <= UTRD_STOP;
                    end
                end
                UTRD_STOP: begin
                    if (tx_tick & cf.two_stop & ~tx_stop2_r) begin
                        tx_stop2_r <= 1'b1;
                    end else if (tx_load) begin
                        tx_st_r <= UTRD_START;
                    end else if (tx_last) begin
                        tx_st_r <= UTRD_IDLE;
                    end
                end
                default: tx_st_r <= UTRD_IDLE;
            endcase
        end
    end

    // line level follows the state one cycle later; idle line is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd_r <= 1'b1;
        end else begin
            unique case (tx_st_r)
                UTRD_START: txd_r <= 1'b0;
                UTRD_DATA: txd_r <= tx_sh_r[tx_cnt_r];
                UTRD_PAR: txd_r <= tx_par_r;
                default: txd_r <= 1'b1;
            endcase
        end
    end

    // effective enable: turning off waits for shifter and buffer to drain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transmitter_enable_eff_r <= 1'b0;
            txd_oe_r <= 1'b0;
        end else begin
            if (cf.transmitter_enable) begin
                transmitter_enable_eff_r <= 1'b1;
            end else if ((tx_st_r == UTRD_IDLE) & ~buf_full_r) begin
                transmitter_enable_eff_r <= 1'b0;
            end
            txd_oe_r <= transmitter_enable_eff_r;
        end
    end

    // transmit-complete: a new completion beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdone_r <= 1'b0;
        end else if (tx_last & ~buf_full_r) begin
            tdone_r <= 1'b1;
        end else if (tdone_ack_i | (wr_stat & wb_dat_i[UTRD_ST_TDONE])) begin
            tdone_r <= 1'b0;
        end
    end

    // receive sampling: mid-bit by divisor, or rising transfer clock
    assign rx_samp = cf.sync_mode ? xck_rise : (rx_div_r == 16'h0000);
    assign rx_done = (rx_st_r == UTRD_STOP) & rx_samp;

    // half a bit preset while idle puts async samples mid-bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_div_r <= 16'h0000;
        end else if (rx_st_r == UTRD_IDLE) begin
            rx_div_r <= {1'b0, baud_r[15:1]};
        end else if (rx_div_r == 16'h0000) begin
            rx_div_r <= baud_r;
        end else begin
            rx_div_r <= rx_div_r - 16'h0001;
        end
    end

    // receive frame sequencer; parity is only skipped, not checked
    always_ff @(posedge clk_i) begin
        if (rst_i | ~cf.receiver_enable) begin
            rx_st_r <= UTRD_IDLE;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else begin
            unique case (rx_st_r)
                UTRD_IDLE: begin
                    rx_cnt_r <= 4'h0;
                    rx_sh_r <= 9'h000;
                    if (~rxd_s_r & (~cf.sync_mode | xck_rise)) begin
                        rx_st_r <= cf.sync_mode ? UTRD_DATA : UTRD_START;
                    end
                end
                UTRD_START: begin
                    if (rx_samp) begin
                        rx_st_r <= rxd_s_r ? UTRD_IDLE : UTRD_DATA;
                    end
                end
                UTRD_DATA: begin
                    if (rx_samp) begin
                        rx_sh_r[rx_cnt_r] <= rxd_s_r;
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r == nbits - 4'h1) begin
                            rx_st_r <= cf.parity_mode_hi ? UTRD_PAR : UTRD_STOP;
                        end
                    end
                end
                UTRD_PAR: begin
                    if (rx_samp) begin
                        rx_st_r <= UTRD_STOP;
                    end
                end
                UTRD_STOP: begin
                    if (rx_samp) begin
                        rx_st_r <= UTRD_IDLE;
                    end
                end
                default: rx_st_r <= UTRD_IDLE;
            endcase
        end
    end

    // receive buffer: a new frame beats a pop; disable flushes it
    always_ff @(posedge clk_i) begin
        if (rst_i | ~cf.receiver_enable) begin
            rx_full_r <= 1'b0;
            rxb_r <= '0;
        end else if (rx_done) begin
            rx_full_r <= 1'b1;
            rxb_r <= utrd_char_t'(rx_sh_r);
        end else if (rd_data) begin
            rx_full_r <= 1'b0;
        end
    end

    // pin ownership and interrupt request levels, all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_own_r <= 1'b0;
            tbe_irq_r <= 1'b0;
            tdone_irq_r <= 1'b0;
            rfull_irq_r <= 1'b0;
        end else begin
            rx_own_r <= cf.receiver_enable;
            tbe_irq_r <= cf.tx_buffer_empty_irq_en & ~buf_full_r;
            tdone_irq_r <= cf.tx_complete_irq_en & tdone_r;
            rfull_irq_r <= cf.rx_complete_irq_en & rx_full_r;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign txd_o = txd_r;
    assign txd_oe_o = txd_oe_r;
    assign rx_pin_own_o = rx_own_r;
    assign tbe_irq_o = tbe_irq_r;
    assign tdone_irq_o = tdone_irq_r;
    assign rfull_irq_o = rfull_irq_r;

    // checks on the transmit and receive paths
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_WR_FILLS: assert property (wr_data |=> buf_full_r ##1 (tbe_irq_o == 1'b0)
        or ~cf.tx_buffer_empty_irq_en) else $error("data write did not fill buffer");
    AST_MOVE: assert property ((tx_st_r == UTRD_IDLE) & buf_full_r & transmitter_enable_eff_r & ~wr_data
        |=> (tx_st_r == UTRD_START) & ~buf_full_r) else $error("idle shifter did not load");
    AST_TDONE_SET: assert property (tx_last & ~buf_full_r |=> tdone_r)
        else $error("transmit complete not set");
    AST_TDONE_IRQ: assert property (tdone_r & cf.tx_complete_irq_en |=> tdone_irq_o)
        else $error("transmit complete request missing");
    AST_TBE_IRQ: assert property ((~buf_full_r & cf.tx_buffer_empty_irq_en) [*2]
        |-> tbe_irq_o) else $error("buffer empty request missing");
    AST_DRAIN: assert property ((tx_st_r != UTRD_IDLE) |-> transmitter_enable_eff_r ##2 txd_oe_o)
        else $error("transmitter released while busy");
    AST_PAR_ONLY: assert property ((tx_st_r == UTRD_PAR) |-> cf.parity_mode_hi)
        else $error("parity sent with parity off");
    AST_RX_FLUSH: assert property (~cf.receiver_enable |=> ~rx_full_r ##1 ~rfull_irq_o)
        else $error("receive buffer not flushed");
    AST_RX_MOVE: assert property (rx_done & cf.receiver_enable |=> rx_full_r
        & (rxb_r == $past(rx_sh_r))) else $error("frame not moved to buffer");
    AST_RX_MASK: assert property (rx_full_r |-> ((rxb_r & ~dmask) == 9'h000))
        else $error("upper receive bits not zero");

    COV_BACK2BACK: cover property (tx_last ##1 (tx_st_r == UTRD_START));
    COV_RX_FRAME: cover property (rx_done ##[1:1000] rd_data);
    COV_DISABLE_WAIT: cover property (~cf.transmitter_enable & (tx_st_r == UTRD_DATA)
        ##[1:1000] ~transmitter_enable_eff_r);
endmodule // utrd_datapath

// ===== utrd_remote.sv
// remote serial transceiver model on the far side of the line pins
// assumes the system clock paces bits; bit_cyc must match the programmed bit length
`timescale 1ns/1ps
module utrd_remote (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic txd_oe_i,
    output logic rxd_o,
    output logic xck_o
);
    int bit_cyc = 4;
    int nbits = 8;
    logic par_en = 1'b0;
    logic [8:0] got_char;
    logic got_par;
    logic got_stop;
    int got_cnt = 0;
    logic [8:0] d;
    logic line;

    // a released transmit pin reads idle high through its pull-up
    assign line = txd_oe_i ? txd_i : 1'b1;

    // idle line high; transfer clock stands still low between frames
    initial begin
        rxd_o = 1'b1;
        xck_o = 1'b0;
    end

    // decoder waits to mid start bit unchecked, then samples mid-bit: data lsb first, optional parity, first stop
    always begin
        @(posedge clk_i);
        if (line === 1'b0) begin
            repeat (bit_cyc / 2) @(posedge clk_i);
            d = '0;
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_cyc) @(posedge clk_i);
                d[i] = line;
            end
            if (par_en) begin
                repeat (bit_cyc) @(posedge clk_i);
                got_par = line;
            end
            repeat (bit_cyc) @(posedge clk_i);
            got_stop = line;
            got_char = d;
            got_cnt++;
        end
    end

    // asynchronous frame towards the receiver; stops beyond the first are ignored there
    task automatic send_async(input logic [8:0] c, input int n, input int stops);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (bit_cyc) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            rxd_o <= c[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (bit_cyc * stops) @(posedge clk_i);
    endtask

    // synchronous frame: data changes with the clock low, sampled on its rising edge
    task automatic send_sync(input logic [8:0] c, input int n);
        for (int i = -1; i <= n; i++) begin
            @(posedge clk_i);
            rxd_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : c[i];
            repeat (3) @(posedge clk_i);
            xck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            xck_o <= 1'b0;
        end
    endtask
endmodule // utrd_remote

// ===== tb_top.sv
// self-checking bench for the serial data path over classic wishbone
// assumes utrd_remote on the line pins; bit length programmed to four cycles
`timescale 1ns/1ps
module tb_top
    import utrd_pkg::*;
;
    logic clk_i, rst_i, cyc, stb, we, ack, txd, txd_oe, rxd, own, transfer_clock_pin, tack;
    logic tbe_irq, tdone_irq, rfull_irq;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, v;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    utrd_datapath i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .txd_o(txd), .txd_oe_o(txd_oe), .rxd_i(rxd), .rx_pin_own_o(own),
        .xck_i(transfer_clock_pin), .tdone_ack_i(tack), .tbe_irq_o(tbe_irq), .tdone_irq_o(tdone_irq),
        .rfull_irq_o(rfull_irq));
    utrd_remote i_remote (.clk_i(clk_i), .txd_i(txd), .txd_oe_i(txd_oe), .rxd_o(rxd),
        .xck_o(transfer_clock_pin));

    // 40 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // hang guard: a whole run needs well under this many cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) chk("ack", 32'h1, {31'h0, ack});
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, v & m);
    endtask

    // outputs are looked at on the falling edge, well clear of updates
    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic wait_tx(input int c);
        int n;
        n = 0;
        while (i_remote.got_cnt < c && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000) chk("tx_count", c, i_remote.got_cnt);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // main sequence: registers, transmit, parity, ninth bit, disable, receive
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, tack} = 4'h0;
        adr = 5'h00;
        sel = 4'h0;
        wdat = 32'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", UTRD_OFS_CTRL, 32'h1FFF, 32'h00C0);
        rd("baud", UTRD_OFS_BAUD, 32'hFFFF, 32'h0103);
        rd("stat", UTRD_OFS_STAT, 32'hF, 32'h1);
        rd("unmapped", 5'h10, 32'hFFFFFFFF, 32'h0);
        wr(UTRD_OFS_BAUD, 32'h3);
        wr(UTRD_OFS_CTRL, 32'h00DF);
        pause(2);
        chk("own", 1, own);
        chk("tbe_irq", 1, tbe_irq);
        wr(UTRD_OFS_DATA, 32'hA5);
        wr(UTRD_OFS_DATA, 32'h3C);
        rd("stat", UTRD_OFS_STAT, 32'h3, 32'h0);
        pause(0);
        chk("tbe_irq", 0, tbe_irq);
        wait_tx(1);
        chk("tx1", 32'hA5, i_remote.got_char);
        wait_tx(2);
        chk("tx2", 32'h3C, i_remote.got_char);
        pause(12);
        rd("stat", UTRD_OFS_STAT, 32'h3, 32'h3);
        chk("tdone_irq", 1, tdone_irq);
        wr(UTRD_OFS_STAT, 32'h2);
        rd("stat", UTRD_OFS_STAT, 32'h2, 32'h0);
        pause(2);
        chk("tdone_irq", 0, tdone_irq);
        chk("tbe_irq", 1, tbe_irq);
        // handler with nothing to send turns the empty request off
        wr(UTRD_OFS_CTRL, 32'h00DB);
        pause(2);
        chk("tbe_irq", 0, tbe_irq);
        wr(UTRD_OFS_DATA, 32'h81);
        wait_tx(3);
        pause(12);
        chk("tdone_irq", 1, tdone_irq);
        @(posedge clk_i);
        tack <= 1'b1;
        @(posedge clk_i);
        tack <= 1'b0;
        rd("stat", UTRD_OFS_STAT, 32'h2, 32'h0);
        // seven-bit characters with even then odd parity
        i_remote.nbits = 7;
        i_remote.par_en = 1'b1;
        for (int p = 0; p < 2; p++) begin
            wr(UTRD_OFS_CTRL, 32'h0283 | (p << 10));
            wr(UTRD_OFS_DATA, 32'hD3);
            wait_tx(4 + p);
            chk("tx7", 32'h53, i_remote.got_char);
            chk("par", (^7'h53) ^ p[0], i_remote.got_par);
            chk("stop", 1, i_remote.got_stop);
        end
        // ninth bit set in control before the low byte goes in
        i_remote.nbits = 9;
        i_remote.par_en = 1'b0;
        wr(UTRD_OFS_CTRL, 32'h01E3);
        wr(UTRD_OFS_DATA, 32'h55);
        wait_tx(6);
        chk("tx9", 32'h155, i_remote.got_char);
        // disable with one frame on the line and one waiting
        i_remote.nbits = 8;
        wr(UTRD_OFS_CTRL, 32'h00C3);
        wr(UTRD_OFS_DATA, 32'h11);
        wr(UTRD_OFS_DATA, 32'h22);
        wr(UTRD_OFS_CTRL, 32'h00C2);
        pause(1);
        chk("txd_oe", 1, txd_oe);
        wait_tx(8);
        chk("tx_last", 32'h22, i_remote.got_char);
        pause(12);
        chk("txd_oe", 0, txd_oe);
        // receive path: two stop bits, short characters, flush, synchronous
        wr(UTRD_OFS_CTRL, 32'h00D2);
        i_remote.send_async(9'h05A, 8, 2);
        pause(4);
        chk("rfull_irq", 1, rfull_irq);
        rd("stat", UTRD_OFS_STAT, 32'h4, 32'h4);
        rd("data", UTRD_OFS_DATA, 32'hFF, 32'h5A);
        rd("stat", UTRD_OFS_STAT, 32'h4, 32'h0);
        wr(UTRD_OFS_CTRL, 32'h0052);
        i_remote.send_async(9'h02B, 6, 1);
        pause(4);
        rd("data6", UTRD_OFS_DATA, 32'hFFFFFFFF, 32'h2B);
        i_remote.send_async(9'h00F, 6, 1);
        pause(4);
        rd("stat", UTRD_OFS_STAT, 32'h4, 32'h4);
        wr(UTRD_OFS_CTRL, 32'h0040);
        rd("stat", UTRD_OFS_STAT, 32'h4, 32'h0);
        pause(2);
        chk("own", 0, own);
        wr(UTRD_OFS_CTRL, 32'h10C2);
        i_remote.send_sync(9'h0C3, 8);
        pause(6);
        rd("sync", UTRD_OFS_DATA, 32'hFF, 32'hC3);
        test_done();
    end
endmodule // tb_top
